// ### hdl/bridge_err_pkg.sv
// Constants, types and field layout for the bridge error and retry alias registers
package bridge_err_pkg;
    localparam logic [7:0]  STATUS_OFFSET  = 8'h68;
    localparam logic [7:0]  OPTION_OFFSET  = 8'h74;
    localparam logic [7:0]  DISABLE_OFFSET = 8'h64;
    localparam logic [7:0]  CONTROL_OFFSET = 8'h78;
    localparam logic [7:0]  INT_MASK_OFFSET = 8'h7c;
    localparam int          STATUS_LSB     = 16;
    localparam int          NUM_EVENTS     = 8;
    localparam logic [7:0]  STATUS_RESET   = 8'h00;
    localparam logic [7:0]  DISABLE_RESET  = 8'h00;
    localparam logic [7:0]  MASK_RESET     = 8'h00;
    localparam logic [6:0]  OPTION_RESET   = 7'h6a;
    localparam logic [6:0]  OPTION_WMASK   = 7'h7e;
    localparam int          OPT_P_RD       = 1;
    localparam int          OPT_P_WR       = 2;
    localparam int          OPT_S_RD       = 3;
    localparam int          OPT_S_WR       = 4;
    localparam int          OPT_P_LM       = 5;
    localparam int          OPT_S_LM       = 6;
    localparam logic [3:0]  plain_mem_read_cmd   = 4'h6;
    localparam logic [3:0]  plain_mem_write_cmd  = 4'h7;
    localparam logic [3:0]  multi_mem_read_cmd   = 4'hc;
    localparam logic [3:0]  line_mem_read_cmd    = 4'he;
    localparam logic [3:0]  write_invalidate_cmd = 4'hf;
    localparam logic [1:0]  HTRANS_NONSEQ  = 2'b10;

    typedef struct packed {
        logic [7:0] status;
        logic [7:0] disable_mask;
        logic [7:0] int_mask;
        logic [6:0] option;
        logic       serr_enable;
        logic       serr_out;
        logic       pend;
        logic       pend_write;
        logic [7:0] pend_addr;
        logic [31:0] rdata;
    } bank_state_s;

    typedef struct packed {
        logic [3:0] orig_cmd;
        logic [3:0] retry_cmd;
        logic       secondary;
    } retry_query_s;
endpackage

// ### hdl/bridge_error_status_and_retry_alias.sv
// Error cause status and port option registers with AHB-Lite access
//
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/100ps
module bridge_error_status_and_retry_alias
(
    // Clock and reset
    input  wire logic                          clk_i,
    input  wire logic                          reset_i,
    // AHB-Lite slave
    input  wire logic                          hsel_i,
    input  wire logic [7:0]                    haddr_i,
    input  wire logic [1:0]                    htrans_i,
    input  wire logic                          hwrite_i,
    input  wire logic [2:0]                    hsize_i,
    input  wire logic [31:0]                   hwdata_i,
    input  wire logic                          hready_i,
    output logic      [31:0]                   hrdata_o,
    output logic                               hreadyout_o,
    output logic                               hresp_o,
    // Bridge error events, one-cycle pulses, bit order as status field
    input  wire logic [7:0]                    event_i,
    // Retry match query
    input  wire bridge_err_pkg::retry_query_s  query_i,
    output logic                               retry_match_o,
    // System error and interrupt
    output logic                               primary_system_error_out_o,
    output logic                               irq_o
);
    bridge_err_pkg::bank_state_s state_r;
    bridge_err_pkg::bank_state_s state_nxt;

    logic       take;
    logic [7:0] clr;
    logic [7:0] gated;
    logic [3:0] oc;
    logic [3:0] rc;
    logic       rd_alias;
    logic       wr_alias;
    logic       lm_alias;

    assign take = hsel_i && hready_i && (htrans_i == bridge_err_pkg::HTRANS_NONSEQ);

    always_comb
    begin
        state_nxt = state_r;
        clr       = 8'h00;
        gated     = event_i & ~state_r.disable_mask & {8{state_r.serr_enable}};
        if (state_r.pend && state_r.pend_write)
        begin
            case (state_r.pend_addr)
                bridge_err_pkg::STATUS_OFFSET:
                    clr = hwdata_i[bridge_err_pkg::STATUS_LSB +: 8];
                bridge_err_pkg::OPTION_OFFSET:
                    state_nxt.option = hwdata_i[6:0] & bridge_err_pkg::OPTION_WMASK;
                bridge_err_pkg::DISABLE_OFFSET:
                    state_nxt.disable_mask = hwdata_i[7:0];
                bridge_err_pkg::CONTROL_OFFSET:
                    state_nxt.serr_enable = hwdata_i[0];
                bridge_err_pkg::INT_MASK_OFFSET:
                    state_nxt.int_mask = hwdata_i[7:0];
                default:
                    clr = 8'h00;
            endcase
        end
        state_nxt.status   = (state_r.status & ~clr) | gated;
        state_nxt.serr_out = |gated;
        state_nxt.pend     = take;
        state_nxt.pend_write = hwrite_i;
        state_nxt.pend_addr  = haddr_i;
        if (take && !hwrite_i)
        begin
            case (haddr_i)
                bridge_err_pkg::STATUS_OFFSET:
                    state_nxt.rdata = {8'h00, state_r.status, 16'h0000};
                bridge_err_pkg::OPTION_OFFSET:
                    state_nxt.rdata = {25'h000_0000, state_r.option};
                bridge_err_pkg::DISABLE_OFFSET:
                    state_nxt.rdata = {24'h00_0000, state_r.disable_mask};
                bridge_err_pkg::CONTROL_OFFSET:
                    state_nxt.rdata = {31'h0000_0000, state_r.serr_enable};
                bridge_err_pkg::INT_MASK_OFFSET:
                    state_nxt.rdata = {24'h00_0000, state_r.int_mask};
                default:
                    state_nxt.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            state_r              <= '0;
            state_r.status       <= bridge_err_pkg::STATUS_RESET;
            state_r.disable_mask <= bridge_err_pkg::DISABLE_RESET;
            state_r.int_mask     <= bridge_err_pkg::MASK_RESET;
            state_r.option       <= bridge_err_pkg::OPTION_RESET;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // Zero wait states keep the slave simple; every access completes next cycle
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;
    assign hrdata_o    = state_r.rdata;
    assign primary_system_error_out_o = state_r.serr_out;
    assign irq_o       = |(state_r.status & state_r.int_mask);

    assign oc = query_i.orig_cmd;
    assign rc = query_i.retry_cmd;

    always_comb
    begin
        // line or multiple read aliases plain read
        rd_alias = query_i.secondary ? state_r.option[bridge_err_pkg::OPT_S_RD]
                                     : state_r.option[bridge_err_pkg::OPT_P_RD];
        wr_alias = query_i.secondary ? state_r.option[bridge_err_pkg::OPT_S_WR]
                                     : state_r.option[bridge_err_pkg::OPT_P_WR];
        // line and multiple alias each other
        lm_alias = query_i.secondary ? state_r.option[bridge_err_pkg::OPT_S_LM]
                                     : state_r.option[bridge_err_pkg::OPT_P_LM];
        retry_match_o = (oc == rc);
        if (rd_alias && (oc == bridge_err_pkg::plain_mem_read_cmd) &&
            ((rc == bridge_err_pkg::line_mem_read_cmd) ||
             (rc == bridge_err_pkg::multi_mem_read_cmd)))
            retry_match_o = 1'b1;
        if (rd_alias && (rc == bridge_err_pkg::plain_mem_read_cmd) &&
            ((oc == bridge_err_pkg::line_mem_read_cmd) ||
             (oc == bridge_err_pkg::multi_mem_read_cmd)))
            retry_match_o = 1'b1;
        if (wr_alias &&
            (((oc == bridge_err_pkg::plain_mem_write_cmd) &&
              (rc == bridge_err_pkg::write_invalidate_cmd)) ||
             ((oc == bridge_err_pkg::write_invalidate_cmd) &&
              (rc == bridge_err_pkg::plain_mem_write_cmd))))
            retry_match_o = 1'b1;
        if (lm_alias &&
            (((oc == bridge_err_pkg::line_mem_read_cmd) &&
              (rc == bridge_err_pkg::multi_mem_read_cmd)) ||
             ((oc == bridge_err_pkg::multi_mem_read_cmd) &&
              (rc == bridge_err_pkg::line_mem_read_cmd))))
            retry_match_o = 1'b1;
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    sequence s_status_clear;
        state_r.pend && state_r.pend_write &&
        (state_r.pend_addr == bridge_err_pkg::STATUS_OFFSET) &&
        hwdata_i[bridge_err_pkg::STATUS_LSB] && !gated[0];
    endsequence

    chk_addr_parity_set: assert property (gated[0] |=> state_r.status[0])
        else $error("address parity flag not set");
    chk_posted_parity_set: assert property (gated[1] |=> state_r.status[1])
        else $error("posted parity flag not set");
    chk_posted_nodeliv_set: assert property (gated[2] |=> state_r.status[2])
        else $error("posted non-delivery flag not set");
    chk_target_abort_set: assert property (gated[3] |=> state_r.status[3])
        else $error("target abort flag not set");
    chk_master_abort_set: assert property (gated[4] |=> state_r.status[4])
        else $error("master abort flag not set");
    chk_delayed_wr_set: assert property (gated[5] |=> state_r.status[5])
        else $error("delayed write flag not set");
    chk_delayed_rd_set: assert property (gated[6] |=> state_r.status[6])
        else $error("delayed read flag not set");
    chk_master_tmo_set: assert property (gated[7] |=> state_r.status[7])
        else $error("master timeout flag not set");
    chk_status_w1c: assert property (s_status_clear |=> !state_r.status[0])
        else $error("status flag not cleared by write one");
    chk_status_sticky: assert property
        (state_r.status[1] && !(state_r.pend && state_r.pend_write) |=> state_r.status[1])
        else $error("status flag dropped without clear");
    chk_option_reserved: assert property (!state_r.option[0])
        else $error("reserved option bit set");
    chk_serr_gate: assert property
        (primary_system_error_out_o |-> $past(state_r.serr_enable))
        else $error("system error without enable");
    chk_alias_exact: assert property
        (!state_r.option[bridge_err_pkg::OPT_P_RD] && !query_i.secondary &&
         query_i.orig_cmd == bridge_err_pkg::plain_mem_read_cmd &&
         query_i.retry_cmd == bridge_err_pkg::line_mem_read_cmd |-> !retry_match_o)
        else $error("primary read aliased while exact");

    // Multi-step behaviours are built from these pieces
    sequence s_gated_event;
        |gated;
    endsequence

    sequence s_no_gated_event;
        gated == 8'h00;
    endsequence

    sequence s_status_read;
        take && !hwrite_i && (haddr_i == bridge_err_pkg::STATUS_OFFSET);
    endsequence

    sequence s_option_read;
        take && !hwrite_i && (haddr_i == bridge_err_pkg::OPTION_OFFSET);
    endsequence

    sequence s_option_write;
        state_r.pend && state_r.pend_write &&
        (state_r.pend_addr == bridge_err_pkg::OPTION_OFFSET);
    endsequence

    sequence s_control_write;
        state_r.pend && state_r.pend_write &&
        (state_r.pend_addr == bridge_err_pkg::CONTROL_OFFSET);
    endsequence

    sequence s_prim_query;
        !query_i.secondary;
    endsequence

    sequence s_sec_query;
        query_i.secondary;
    endsequence

    // system error follows a gated event
    chk_serr_follows: assert property (s_gated_event |=> primary_system_error_out_o)
        else $error("system error missing after gated event");

    // no gated event means no system error
    chk_serr_quiet: assert property (s_no_gated_event |=> !primary_system_error_out_o)
        else $error("system error without gated event");

    // enable bit clear keeps the output low
    chk_serr_disabled: assert property
        (!state_r.serr_enable |=> !primary_system_error_out_o)
        else $error("system error while enable clear");

    // control bit write reaches the enable
    chk_enable_write: assert property
        ((s_control_write ##0 hwdata_i[0]) |=> state_r.serr_enable)
        else $error("system error enable not written");

    // a gated event always lands, even against a clear
    chk_set_wins: assert property
        (1'b1 |=> (state_r.status & $past(gated)) == $past(gated))
        else $error("event lost against clear");

    // Per-bit status behaviour, one copy per event
    for (genvar k = 0; k < bridge_err_pkg::NUM_EVENTS; k++)
    begin : g_bit_chk
        chk_bit_sticky: assert property
            (state_r.status[k] && !clr[k] |=> state_r.status[k])
            else $error("status flag lost without clear");

        // write one clears when no new event
        chk_bit_clear: assert property
            (clr[k] && !gated[k] |=> !state_r.status[k])
            else $error("status flag not cleared");

        // a flag only rises from a gated event
        chk_bit_origin: assert property
            (!state_r.status[k] && !gated[k] |=> !state_r.status[k])
            else $error("status flag rose without gated event");

        // Unmasked flag drives the interrupt
        chk_bit_irq: assert property
            (state_r.status[k] && state_r.int_mask[k] |-> irq_o)
            else $error("interrupt low with unmasked flag");
    end

    // Interrupt stays low when nothing unmasked is pending
    chk_irq_quiet: assert property
        ((state_r.status & state_r.int_mask) == 8'h00 |-> !irq_o)
        else $error("interrupt high with nothing pending");

    // Zero wait states and an OKAY response always
    chk_hready_high: assert property (hreadyout_o)
        else $error("ready dropped");

    chk_hresp_okay: assert property (!hresp_o)
        else $error("error response given");

    // status read returns the flags in bits 23 to 16
    chk_status_rdata: assert property
        (s_status_read |=> hrdata_o == {8'h00, $past(state_r.status), 16'h0000})
        else $error("status read data wrong");

    // option read keeps reserved and upper bits zero
    chk_option_rdata: assert property
        (s_option_read |=> (hrdata_o[31:7] == 25'h000_0000) && !hrdata_o[0])
        else $error("option read data has reserved bits set");

    // writing the reserved bit leaves it zero
    chk_option_rsvd_wr: assert property (s_option_write |=> !state_r.option[0])
        else $error("reserved option bit written");

    // primary read alias bit takes a written one
    chk_option_p_rd_wr: assert property
        ((s_option_write ##0 hwdata_i[bridge_err_pkg::OPT_P_RD]) |=>
         state_r.option[bridge_err_pkg::OPT_P_RD])
        else $error("primary read alias bit not written");

    // primary write alias bit takes a written one
    chk_option_p_wr_wr: assert property
        ((s_option_write ##0 hwdata_i[bridge_err_pkg::OPT_P_WR]) |=>
         state_r.option[bridge_err_pkg::OPT_P_WR])
        else $error("primary write alias bit not written");

    // Identical commands always match
    chk_same_cmd: assert property
        (query_i.orig_cmd == query_i.retry_cmd |-> retry_match_o)
        else $error("identical commands did not match");

    // primary multiple read matches plain read when aliased
    chk_alias_p_rd: assert property
        ((s_prim_query ##0 state_r.option[bridge_err_pkg::OPT_P_RD] &&
          query_i.orig_cmd == bridge_err_pkg::plain_mem_read_cmd &&
          query_i.retry_cmd == bridge_err_pkg::multi_mem_read_cmd) |-> retry_match_o)
        else $error("primary read alias missed");

    // primary write-invalidate matches plain write when aliased
    chk_alias_p_wr: assert property
        ((s_prim_query ##0 state_r.option[bridge_err_pkg::OPT_P_WR] &&
          query_i.orig_cmd == bridge_err_pkg::plain_mem_write_cmd &&
          query_i.retry_cmd == bridge_err_pkg::write_invalidate_cmd) |-> retry_match_o)
        else $error("primary write alias missed");

    chk_exact_p_wr: assert property
        ((s_prim_query ##0 !state_r.option[bridge_err_pkg::OPT_P_WR] &&
          query_i.orig_cmd == bridge_err_pkg::plain_mem_write_cmd &&
          query_i.retry_cmd == bridge_err_pkg::write_invalidate_cmd) |-> !retry_match_o)
        else $error("primary write aliased while exact");

    // secondary line read matches plain read when aliased
    chk_alias_s_rd: assert property
        ((s_sec_query ##0 state_r.option[bridge_err_pkg::OPT_S_RD] &&
          query_i.orig_cmd == bridge_err_pkg::plain_mem_read_cmd &&
          query_i.retry_cmd == bridge_err_pkg::line_mem_read_cmd) |-> retry_match_o)
        else $error("secondary read alias missed");

    // exact matching refuses the line read
    chk_exact_s_rd: assert property
        ((s_sec_query ##0 !state_r.option[bridge_err_pkg::OPT_S_RD] &&
          query_i.orig_cmd == bridge_err_pkg::plain_mem_read_cmd &&
          query_i.retry_cmd == bridge_err_pkg::line_mem_read_cmd) |-> !retry_match_o)
        else $error("secondary read aliased while exact");

    // secondary write-invalidate matches plain write when aliased
    chk_alias_s_wr: assert property
        ((s_sec_query ##0 state_r.option[bridge_err_pkg::OPT_S_WR] &&
          query_i.orig_cmd == bridge_err_pkg::plain_mem_write_cmd &&
          query_i.retry_cmd == bridge_err_pkg::write_invalidate_cmd) |-> retry_match_o)
        else $error("secondary write alias missed");

    chk_exact_s_wr: assert property
        ((s_sec_query ##0 !state_r.option[bridge_err_pkg::OPT_S_WR] &&
          query_i.orig_cmd == bridge_err_pkg::plain_mem_write_cmd &&
          query_i.retry_cmd == bridge_err_pkg::write_invalidate_cmd) |-> !retry_match_o)
        else $error("secondary write aliased while exact");

    // primary line and multiple reads match when aliased
    chk_alias_p_lm: assert property
        ((s_prim_query ##0 state_r.option[bridge_err_pkg::OPT_P_LM] &&
          query_i.orig_cmd == bridge_err_pkg::line_mem_read_cmd &&
          query_i.retry_cmd == bridge_err_pkg::multi_mem_read_cmd) |-> retry_match_o)
        else $error("primary line multiple alias missed");

    // exact matching keeps line and multiple apart
    chk_exact_p_lm: assert property
        ((s_prim_query ##0 !state_r.option[bridge_err_pkg::OPT_P_LM] &&
          query_i.orig_cmd == bridge_err_pkg::line_mem_read_cmd &&
          query_i.retry_cmd == bridge_err_pkg::multi_mem_read_cmd) |-> !retry_match_o)
        else $error("primary line multiple aliased while exact");

    // secondary line and multiple reads match when aliased
    chk_alias_s_lm: assert property
        ((s_sec_query ##0 state_r.option[bridge_err_pkg::OPT_S_LM] &&
          query_i.orig_cmd == bridge_err_pkg::multi_mem_read_cmd &&
          query_i.retry_cmd == bridge_err_pkg::line_mem_read_cmd) |-> retry_match_o)
        else $error("secondary line multiple alias missed");

    // exact matching keeps line and multiple apart
    chk_exact_s_lm: assert property
        ((s_sec_query ##0 !state_r.option[bridge_err_pkg::OPT_S_LM] &&
          query_i.orig_cmd == bridge_err_pkg::multi_mem_read_cmd &&
          query_i.retry_cmd == bridge_err_pkg::line_mem_read_cmd) |-> !retry_match_o)
        else $error("secondary line multiple aliased while exact");

    // The side bit selects which option set applies; a primary alias must
    // never leak into a secondary query, which the exact checks above catch
endmodule // bridge_error_status_and_retry_alias

// ### verif/bridge_far_side.sv
// Far-side model: bridge core raising error events and retry command queries
`timescale 1ns/100ps
module bridge_far_side
(
    // Clock
    input  wire logic                    clk_i,
    // Events and retry query toward the bank
    output logic [7:0]                   event_o,
    output bridge_err_pkg::retry_query_s query_o
);
    initial event_o = 8'h00;
    initial query_o = '0;
    // Events last exactly one cycle, as the core never holds them
    task automatic pulse(input logic [7:0] m);
        @(posedge clk_i);
        event_o <= m;
        @(posedge clk_i);
        event_o <= 8'h00;
    endtask
    task automatic ask(input logic s, input logic [3:0] o, input logic [3:0] r);
        @(posedge clk_i);
        query_o <= '{orig_cmd: o, retry_cmd: r, secondary: s};
    endtask
endmodule // bridge_far_side

// ### verif/bridge_error_status_and_retry_alias_test.sv
// Self-checking bench for the error status and retry alias register bank
`timescale 1ns/100ps
module bridge_error_status_and_retry_alias_test;
    logic                         clk_i = 1'b0;
    logic                         reset_i = 1'b1;
    logic                         hsel_i = 1'b0;
    logic [7:0]                   haddr_i = 8'h00;
    logic [1:0]                   htrans_i = 2'b00;
    logic                         hwrite_i = 1'b0;
    logic [2:0]                   hsize_i = 3'h2;
    logic [31:0]                  hwdata_i = 32'h0000_0000;
    logic [31:0]                  hrdata_o;
    logic                         hreadyout_o;
    logic                         hresp_o;
    logic [7:0]                   event_w;
    bridge_err_pkg::retry_query_s query_w;
    logic                         retry_match_o;
    logic                         serr_o;
    logic                         irq_o;
    int                           fails = 0;
    int                           compares = 0;
    initial forever #2 clk_i = ~clk_i;
    bridge_far_side far (.clk_i(clk_i), .event_o(event_w), .query_o(query_w));
    bridge_error_status_and_retry_alias dut (
        .clk_i(clk_i), .reset_i(reset_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
        .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
        .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
        .hresp_o(hresp_o), .event_i(event_w), .query_i(query_w),
        .retry_match_o(retry_match_o), .primary_system_error_out_o(serr_o), .irq_o(irq_o));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fails++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        hsel_i   <= 1'b1;
        haddr_i  <= a;
        hwrite_i <= w;
        htrans_i <= bridge_err_pkg::HTRANS_NONSEQ;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1 && ++n < 50);
        hsel_i   <= 1'b0;
        htrans_i <= 2'b00;
        hwdata_i <= d;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1 && ++n < 50);
        q = hrdata_o;
        check({31'h0000_0000, hresp_o}, 32'h0000_0000);
    endtask
    task automatic t_reset();
        logic [31:0] q;
        bus(bridge_err_pkg::STATUS_OFFSET, 1'b0, 32'h0000_0000, q);
        check(q, 32'h0000_0000);
        bus(bridge_err_pkg::OPTION_OFFSET, 1'b0, 32'h0000_0000, q);
        check(q, 32'h0000_006a);
        bus(bridge_err_pkg::OPTION_OFFSET, 1'b1, 32'h0000_007f, q);
        bus(bridge_err_pkg::OPTION_OFFSET, 1'b0, 32'h0000_0000, q);
        check(q, 32'h0000_007e);
        bus(8'h70, 1'b1, 32'hffff_ffff, q);
        bus(8'h70, 1'b0, 32'h0000_0000, q);
        check(q, 32'h0000_0000);
        $display("test reset done");
    endtask
    task automatic t_events();
        logic [31:0] q;
        bus(bridge_err_pkg::CONTROL_OFFSET, 1'b1, 32'h0000_0001, q);
        bus(bridge_err_pkg::INT_MASK_OFFSET, 1'b1, 32'h0000_00ff, q);
        for (int k = 0; k < 8; k++)
        begin
            far.pulse(8'h01 << k);
            #1;
            check({31'h0000_0000, serr_o}, 32'h0000_0001);
            @(posedge clk_i);
            #1;
            check({31'h0000_0000, serr_o}, 32'h0000_0000);
            bus(bridge_err_pkg::STATUS_OFFSET, 1'b1, 32'h0000_0000, q);
            bus(bridge_err_pkg::STATUS_OFFSET, 1'b0, 32'h0000_0000, q);
            check(q, 32'h0001_0000 << k);
            check({31'h0000_0000, irq_o}, 32'h0000_0001);
            bus(bridge_err_pkg::STATUS_OFFSET, 1'b1, 32'h0001_0000 << k, q);
            bus(bridge_err_pkg::STATUS_OFFSET, 1'b0, 32'h0000_0000, q);
            check(q, 32'h0000_0000);
        end
        $display("test events done");
    endtask
    task automatic t_gating();
        logic [31:0] q;
        bus(bridge_err_pkg::DISABLE_OFFSET, 1'b1, 32'h0000_0001, q);
        far.pulse(8'h01);
        #1;
        check({31'h0000_0000, serr_o}, 32'h0000_0000);
        bus(bridge_err_pkg::CONTROL_OFFSET, 1'b1, 32'h0000_0000, q);
        far.pulse(8'h04);
        #1;
        check({31'h0000_0000, serr_o}, 32'h0000_0000);
        bus(bridge_err_pkg::STATUS_OFFSET, 1'b0, 32'h0000_0000, q);
        check(q, 32'h0000_0000);
        bus(bridge_err_pkg::CONTROL_OFFSET, 1'b1, 32'h0000_0001, q);
        bus(bridge_err_pkg::INT_MASK_OFFSET, 1'b1, 32'h0000_0000, q);
        far.pulse(8'h08);
        #1;
        check({31'h0000_0000, irq_o}, 32'h0000_0000);
        bus(bridge_err_pkg::INT_MASK_OFFSET, 1'b1, 32'h0000_0008, q);
        #1;
        check({31'h0000_0000, irq_o}, 32'h0000_0001);
        $display("test gating done");
    endtask
    // Option value, side, original and retried command, expected match
    task automatic alias1(input logic [7:0] o, input logic s, input logic [3:0] a,
                          input logic [3:0] b, input logic e);
        logic [31:0] q;
        bus(bridge_err_pkg::OPTION_OFFSET, 1'b1, {24'h00_0000, o}, q);
        far.ask(s, a, b);
        #1;
        check({31'h0000_0000, retry_match_o}, {31'h0000_0000, e});
    endtask
    task automatic t_alias();
        alias1(8'h02, 1'b0, 4'he, 4'h6, 1'b1);
        alias1(8'h02, 1'b1, 4'he, 4'h6, 1'b0);
        alias1(8'h08, 1'b1, 4'hc, 4'h6, 1'b1);
        alias1(8'h04, 1'b0, 4'hf, 4'h7, 1'b1);
        alias1(8'h10, 1'b1, 4'hf, 4'h7, 1'b1);
        alias1(8'h10, 1'b0, 4'hf, 4'h7, 1'b0);
        alias1(8'h20, 1'b0, 4'he, 4'hc, 1'b1);
        alias1(8'h40, 1'b1, 4'hc, 4'he, 1'b1);
        alias1(8'h20, 1'b1, 4'he, 4'hc, 1'b0);
        alias1(8'h00, 1'b0, 4'he, 4'h6, 1'b0);
        alias1(8'h00, 1'b0, 4'h6, 4'h6, 1'b1);
        $display("test alias done");
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        #100000;
        fails++;
        give_verdict();
    end
    initial
    begin
        repeat (16) @(posedge clk_i);
        reset_i <= 1'b0;
        t_reset();
        t_events();
        t_gating();
        t_alias();
        give_verdict();
    end
endmodule // bridge_error_status_and_retry_alias_test
